// File: hdl/mvld_pkg.sv
// Package of constants and carriers for the variable-length decoder control block
package mvld_pkg;
   // ==========================================
   // Status bit positions
   localparam int ST_SUCCESS = 0;
   localparam int ST_SYNC = 1;
   localparam int ST_ERROR = 2;
   localparam int ST_IN_EMPTY = 3;
   localparam int ST_COEF_FULL = 4;
   localparam int ST_HDR_FULL = 5;
   localparam int ST_W = 6;
   // ==========================================
   // Sizes and formats
   localparam logic [7:0] BURST_BYTES = 8'h40;
   localparam logic [3:0] BURST_WORDS = 4'hf;
   localparam logic [2:0] HDR_WORDS_M1 = 3'h4;
   localparam logic [2:0] HDR_WORDS_M2 = 3'h6;
   localparam int RUN_LSB = 16;
   localparam int LEVEL_LSB = 0;
   localparam logic [5:0] SYNC_PREFIX = 6'h18;
   localparam logic [5:0] MAX_EXTRACT = 6'h20;
   localparam logic [31:0] RST_ADDR = 32'h0000_0000;
   localparam logic [15:0] RST_CNT = 16'h0000;
   localparam logic [3:0] DEC_CYCLES = 4'h3;

   typedef enum logic [3:0] {
      CMD_NONE = 4'b0000,
      CMD_PARSE = 4'b0001,
      CMD_EXTRACT = 4'b0010,
      CMD_PEEK = 4'b0011,
      CMD_SKIP = 4'b0100,
      CMD_SEEK = 4'b0101,
      CMD_DRAIN = 4'b0110,
      CMD_RESET = 4'b0111
   } mvld_cmd_e;

   typedef enum logic [2:0] {
      S_IDLE = 3'b000,
      S_FILL = 3'b001,
      S_PARSE = 3'b010,
      S_SHIFT = 3'b011,
      S_SEEK = 3'b100,
      S_DRAIN = 3'b101,
      S_HALT = 3'b110
   } mvld_state_e;

   typedef struct packed {
      logic [31:0] addr;
      logic [15:0] count;
   } mvld_buf_s;

   typedef struct packed {
      logic valid;
      logic hdr;
      logic [31:0] addr;
      logic [31:0] data;
   } mvld_wr_s;

   typedef struct packed {
      mvld_state_e state;
      mvld_cmd_e cmd;
      logic [ST_W-1:0] status;
      logic irq;
      mvld_buf_s inb;
      mvld_buf_s hdrb;
      mvld_buf_s coefb;
      logic [63:0] shreg;
      logic [6:0] fill;
      logic [31:0] result;
      logic [15:0] remain;
      logic [15:0] mb_left;
      logic [2:0] word_idx;
      logic [3:0] hdr_burst;
      logic [3:0] coef_burst;
      logic [3:0] dec_cnt;
      logic rd_req;
      mvld_wr_s wr;
      logic busy;
   } mvld_state_s;
endpackage

// File: hdl/mvld_core.sv
// Control, status and buffer logic of the variable-length decoder
`timescale 1ns/10ps
module mvld_core import mvld_pkg::*; (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst_b,
   // Command
   input wire logic cmd_valid,
   input wire mvld_cmd_e cmd_code,
   input wire logic [15:0] cmd_arg,
   // Configuration
   input wire logic stream_standard_select,
   input wire logic [ST_W-1:0] interrupt_mask,
   input wire logic [7:0] picture_params,
   input wire logic [4:0] load_quant_scale,
   input wire logic [ST_W-1:0] status_clear,
   // Buffer loads
   input wire logic in_load,
   input wire mvld_buf_s in_load_val,
   input wire logic hdr_load,
   input wire mvld_buf_s hdr_load_val,
   input wire logic coef_load,
   input wire mvld_buf_s coef_load_val,
   input wire logic [6:0] fill_restore,
   input wire logic fill_restore_en,
   // Input DMA byte stream
   input wire logic rd_valid,
   input wire logic [7:0] rd_data,
   // Syntax checker verdict
   input wire logic syntax_bad,
   // Outputs
   output logic rd_req,
   output mvld_wr_s wr,
   output logic [ST_W-1:0] status,
   output logic irq,
   output logic busy,
   output logic [31:0] result,
   output mvld_buf_s input_count,
   output mvld_buf_s header_out,
   output mvld_buf_s coef_out,
   output logic [31:0] fifo_context
);
   // ==========================================
   // State
   mvld_state_s cur_ff, nxt_ff;
   logic [5:0] need;
   logic [2:0] hdr_n;

   always_comb begin
      nxt_ff = cur_ff;
      nxt_ff.rd_req = 1'b0;
      nxt_ff.wr.valid = 1'b0;
      need = (cur_ff.remain > 16'h0020) ? MAX_EXTRACT : cur_ff.remain[5:0];
      hdr_n = stream_standard_select ? HDR_WORDS_M2 : HDR_WORDS_M1;
      nxt_ff.status = cur_ff.status & ~status_clear;
      // Buffer loads; an idle halt on the same buffer resumes
      if (in_load) begin
         nxt_ff.inb = in_load_val;
         nxt_ff.status[ST_IN_EMPTY] = 1'b0;
      end
      if (hdr_load) begin
         nxt_ff.hdrb = hdr_load_val;
         nxt_ff.status[ST_HDR_FULL] = 1'b0;
      end
      if (coef_load) begin
         nxt_ff.coefb = coef_load_val;
         nxt_ff.status[ST_COEF_FULL] = 1'b0;
      end
      if (fill_restore_en) begin
         nxt_ff.fill = fill_restore;
      end
      // Byte intake keeps the shift register topped up
      if (rd_valid && cur_ff.fill <= 7'h38) begin
         nxt_ff.shreg = cur_ff.shreg | ({56'h0, rd_data} << (7'h38 - cur_ff.fill));
         nxt_ff.fill = cur_ff.fill + 7'h08;
         nxt_ff.inb.addr = cur_ff.inb.addr + 32'h1;
         nxt_ff.inb.count = cur_ff.inb.count - 16'h1;
      end
      case (cur_ff.state)
         S_IDLE, S_HALT: begin
            if (cmd_valid) begin
               nxt_ff.cmd = cmd_code;
               nxt_ff.status = '0;
               nxt_ff.remain = cmd_arg;
               nxt_ff.mb_left = cmd_arg;
               nxt_ff.word_idx = 3'h0;
               nxt_ff.dec_cnt = '0;
               case (cmd_code)
                  CMD_PARSE: nxt_ff.state = S_PARSE;
                  CMD_EXTRACT, CMD_SKIP: nxt_ff.state = S_SHIFT;
                  CMD_PEEK: begin
                     // Peek capped at MAX_EXTRACT bits, read from the register whatever its fill
                     nxt_ff.result = cur_ff.shreg[63:32] >> (6'h20 - ((cmd_arg[5:0] > MAX_EXTRACT) ?
                        MAX_EXTRACT : cmd_arg[5:0]));
                     nxt_ff.status[ST_SUCCESS] = 1'b1;
                     nxt_ff.state = S_HALT;
                  end
                  CMD_SEEK: nxt_ff.state = S_SEEK;
                  CMD_DRAIN: nxt_ff.state = S_DRAIN;
                  CMD_RESET: begin
                     nxt_ff = '0;
                     nxt_ff.state = S_IDLE;
                  end
                  default: nxt_ff.state = cur_ff.state;
               endcase
            end else if (cur_ff.state == S_HALT && cur_ff.status[ST_SUCCESS] == 1'b0 &&
                  cur_ff.status[ST_SYNC] == 1'b0 && cur_ff.status[ST_ERROR] == 1'b0 &&
                  nxt_ff.status == '0 && cur_ff.cmd != CMD_NONE) begin
               // Stall cleared by a fresh buffer: pick up where it stopped
               case (cur_ff.cmd)
                  CMD_PARSE: nxt_ff.state = S_PARSE;
                  CMD_SEEK: nxt_ff.state = S_SEEK;
                  default: nxt_ff.state = S_SHIFT;
               endcase
            end
         end
         S_SHIFT: begin
            if (cur_ff.remain == 16'h0) begin
               nxt_ff.status[ST_SUCCESS] = 1'b1;
               nxt_ff.state = S_HALT;
            end else if (cur_ff.fill >= {1'b0, need}) begin
               // Extract keeps the bits, skip drops them
               if (cur_ff.cmd == CMD_EXTRACT) begin
                  nxt_ff.result = cur_ff.shreg[63:32] >> (6'h20 - need);
               end
               nxt_ff.shreg = nxt_ff.shreg << need;
               nxt_ff.fill = nxt_ff.fill - {1'b0, need};
               nxt_ff.remain = (cur_ff.cmd == CMD_EXTRACT) ? 16'h0 : cur_ff.remain - {10'h0, need};
            end else if (cur_ff.inb.count == 16'h0) begin
               nxt_ff.status[ST_IN_EMPTY] = 1'b1;
               nxt_ff.state = S_HALT;
            end else begin
               nxt_ff.rd_req = 1'b1;
            end
         end
         S_SEEK: begin
            if (cur_ff.fill >= 7'h20) begin
               if (cur_ff.shreg[63:40] == {16'h0000, 8'h01}) begin
                  nxt_ff.result = cur_ff.shreg[63:32];
                  nxt_ff.status[ST_SYNC] = 1'b1;
                  nxt_ff.state = S_HALT;
               end else begin
                  nxt_ff.shreg = nxt_ff.shreg << 8;
                  nxt_ff.fill = nxt_ff.fill - 7'h08;
               end
            end else if (cur_ff.inb.count == 16'h0) begin
               nxt_ff.status[ST_IN_EMPTY] = 1'b1;
               nxt_ff.state = S_HALT;
            end else begin
               nxt_ff.rd_req = 1'b1;
            end
         end
         S_PARSE: begin
            // Full checks come ahead of success
            if (cur_ff.hdrb.count == 16'h0) begin
               nxt_ff.status[ST_HDR_FULL] = 1'b1;
               nxt_ff.state = S_HALT;
            end else if (cur_ff.coefb.count == 16'h0) begin
               nxt_ff.status[ST_COEF_FULL] = 1'b1;
               nxt_ff.state = S_HALT;
            end else if (cur_ff.mb_left == 16'h0) begin
               nxt_ff.status[ST_SUCCESS] = 1'b1;
               nxt_ff.state = S_HALT;
            end else if (syntax_bad) begin
               nxt_ff.status[ST_ERROR] = 1'b1;
               nxt_ff.state = S_HALT;
            end else if (cur_ff.fill >= 7'h20 && cur_ff.shreg[63:40] == {16'h0000, 8'h01}) begin
               nxt_ff.result = cur_ff.shreg[63:32];
               nxt_ff.status[ST_SYNC] = 1'b1;
               nxt_ff.state = S_HALT;
            end else if (cur_ff.fill < 7'h20) begin
               if (cur_ff.inb.count == 16'h0) begin
                  nxt_ff.status[ST_IN_EMPTY] = 1'b1;
                  nxt_ff.state = S_HALT;
               end else begin
                  nxt_ff.rd_req = 1'b1;
               end
            end else if (cur_ff.dec_cnt != DEC_CYCLES) begin
               nxt_ff.dec_cnt = cur_ff.dec_cnt + 4'h1;
            end else begin
               nxt_ff.dec_cnt = '0;
               nxt_ff.wr.valid = 1'b1;
               if (cur_ff.word_idx != hdr_n) begin
                  // Whole header record first, then one coefficient word
                  nxt_ff.wr.hdr = 1'b1;
                  nxt_ff.wr.addr = cur_ff.hdrb.addr + {24'h0, cur_ff.hdr_burst, 2'b00};
                  nxt_ff.wr.data = {picture_params, 3'h0, load_quant_scale, cur_ff.shreg[63:48]};
                  nxt_ff.hdrb.count = cur_ff.hdrb.count - 16'h1;
                  nxt_ff.hdr_burst = cur_ff.hdr_burst + 4'h1;
                  if (cur_ff.hdr_burst == BURST_WORDS) begin
                     nxt_ff.hdrb.addr = cur_ff.hdrb.addr + {24'h0, BURST_BYTES};
                  end
               end else begin
                  // Coefficient word: run above, level below
                  nxt_ff.wr.hdr = 1'b0;
                  nxt_ff.wr.addr = cur_ff.coefb.addr + {24'h0, cur_ff.coef_burst, 2'b00};
                  nxt_ff.wr.data = {10'h0, cur_ff.shreg[63:58], 8'h0, cur_ff.shreg[57:50]};
                  nxt_ff.coefb.count = cur_ff.coefb.count - 16'h1;
                  nxt_ff.coef_burst = cur_ff.coef_burst + 4'h1;
                  if (cur_ff.coef_burst == BURST_WORDS) begin
                     nxt_ff.coefb.addr = cur_ff.coefb.addr + {24'h0, BURST_BYTES};
                  end
               end
               nxt_ff.shreg = nxt_ff.shreg << 16;
               nxt_ff.fill = nxt_ff.fill - 7'h10;
               if (cur_ff.word_idx == hdr_n) begin
                  nxt_ff.word_idx = 3'h0;
                  nxt_ff.mb_left = cur_ff.mb_left - 16'h1;
               end else begin
                  nxt_ff.word_idx = cur_ff.word_idx + 3'h1;
               end
            end
         end
         S_DRAIN: begin
            // Pad each open burst to 64 bytes
            if (cur_ff.hdr_burst != 4'h0) begin
               nxt_ff.wr = '{valid: 1'b1, hdr: 1'b1, addr: cur_ff.hdrb.addr + {24'h0, cur_ff.hdr_burst, 2'b00},
                  data: 32'h0};
               nxt_ff.hdr_burst = cur_ff.hdr_burst + 4'h1;
               if (cur_ff.hdr_burst == BURST_WORDS) begin
                  nxt_ff.hdrb.addr = cur_ff.hdrb.addr + {24'h0, BURST_BYTES};
               end
            end else if (cur_ff.coef_burst != 4'h0) begin
               nxt_ff.wr = '{valid: 1'b1, hdr: 1'b0, addr: cur_ff.coefb.addr + {24'h0, cur_ff.coef_burst, 2'b00},
                  data: 32'h0};
               nxt_ff.coef_burst = cur_ff.coef_burst + 4'h1;
               if (cur_ff.coef_burst == BURST_WORDS) begin
                  nxt_ff.coefb.addr = cur_ff.coefb.addr + {24'h0, BURST_BYTES};
               end
            end else begin
               nxt_ff.status[ST_SUCCESS] = 1'b1;
               nxt_ff.state = S_HALT;
            end
         end
         default: nxt_ff.state = S_IDLE;
      endcase
      nxt_ff.irq = |(nxt_ff.status & interrupt_mask);
      nxt_ff.busy = (nxt_ff.state != S_IDLE) && (nxt_ff.state != S_HALT);
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         cur_ff <= '0;
      end else begin
         cur_ff <= nxt_ff;
      end
   end

   // ==========================================
   // Outputs straight from state
   assign rd_req = cur_ff.rd_req;
   assign wr = cur_ff.wr;
   assign status = cur_ff.status;
   assign irq = cur_ff.irq;
   assign busy = cur_ff.busy;
   assign result = cur_ff.result;
   assign input_count = cur_ff.inb;
   assign header_out = cur_ff.hdrb;
   assign coef_out = cur_ff.coefb;
   // Bit fill and top bits packed in one word
   assign fifo_context = {cur_ff.fill[6:0], 1'b0, cur_ff.shreg[63:40]};
endmodule // mvld_core

// File: bench/mvld_core_assertions.sv
// Concurrent checks on the decoder control ports
`timescale 1ns/10ps
module mvld_core_assertions import mvld_pkg::*; (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst_b,
   // Controls
   input wire logic cmd_valid,
   input wire mvld_cmd_e cmd_code,
   input wire logic [ST_W-1:0] interrupt_mask,
   input wire logic [ST_W-1:0] status_clear,
   input wire logic in_load,
   input wire logic hdr_load,
   input wire logic coef_load,
   // Results
   input wire mvld_wr_s wr,
   input wire logic [ST_W-1:0] status,
   input wire logic irq,
   input wire logic busy,
   input wire mvld_buf_s input_count
);
   // ==========================================
   // Port relations
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_b);
   logic take;
   logic release_ev;
   logic steady_in;
   assign take = cmd_valid && !busy;
   assign release_ev = take || (|status_clear) || in_load || hdr_load || coef_load;
   assign steady_in = !in_load && !(take && cmd_code == CMD_RESET);
   chk_irq_mask: assert property ($stable(interrupt_mask) |-> irq == |(status & interrupt_mask))
      else $error("irq disagrees with masked status");
   chk_status_sticky: assert property (|($past(status) & ~status) |-> $past(release_ev))
      else $error("status bit dropped without cause");
   chk_peek_answer: assert property (take && cmd_code == CMD_PEEK |-> ##[1:2] status[ST_SUCCESS])
      else $error("peek gave no answer");
   chk_cmd_busy: assert property (take && cmd_code inside {CMD_EXTRACT, CMD_SKIP, CMD_SEEK, CMD_PARSE} |=> busy)
      else $error("command not started");
   chk_word_align: assert property (wr.valid |-> wr.addr[1:0] == 2'h0)
      else $error("write not word aligned");
   chk_in_track: assert property ($past(steady_in) |-> input_count.addr + 32'(input_count.count) ==
      $past(input_count.addr) + 32'($past(input_count.count)))
      else $error("input address and count drift apart");
   chk_full_first: assert property ($rose(status[ST_SUCCESS]) |-> !status[ST_HDR_FULL] && !status[ST_COEF_FULL])
      else $error("success reported with a full buffer");
   chk_reset_cmd: assert property (take && cmd_code == CMD_RESET |=> status == 6'h0 && !busy && input_count.addr == 32'h0)
      else $error("reset command left state behind");
   chk_clear_bits: assert property (|status_clear && !busy && !cmd_valid |=> (status & $past(status_clear)) == 6'h0)
      else $error("status clear ignored");
endmodule // mvld_core_assertions

bind mvld_core mvld_core_assertions i_mvld_core_assertions (.sys_clk, .rst_b, .cmd_valid, .cmd_code,
   .interrupt_mask, .status_clear, .in_load, .hdr_load, .coef_load, .wr, .status, .irq, .busy, .input_count);

// File: bench/mvld_stream_model.sv
// Byte source standing in for the input DMA memory
`timescale 1ns/10ps
module mvld_stream_model (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst_b,
   // Request and pacing
   input wire logic rd_req,
   input wire logic slow,
   // Byte return
   output logic rd_valid,
   output logic [7:0] rd_data
);
   // ==========================================
   // Stream contents, one start code at byte 8
   logic [7:0] mem [64];
   logic [5:0] idx;
   logic [3:0] owed;
   logic [1:0] gap;
   logic send;
   initial begin
      for (int i = 0; i < 64; i++) mem[i] = 8'h80 | 8'(i);
      mem[8] = 8'h00;
      mem[9] = 8'h00;
      mem[10] = 8'h01;
      mem[11] = 8'hb7;
   end
   // ==========================================
   // Answer promptly or after a gap
   assign send = (owed != 4'h0) && (gap == 2'h0);
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         idx <= 6'h0;
         owed <= 4'h0;
         gap <= 2'h0;
         rd_valid <= 1'b0;
         rd_data <= 8'h0;
      end else begin
         rd_valid <= send;
         // Idle data toggles so a stale byte never looks fresh
         rd_data <= send ? mem[idx] : ~rd_data;
         idx <= idx + 6'(send);
         owed <= owed + 4'(rd_req) - 4'(send);
         gap <= send ? (slow ? 2'h2 : 2'h0) : ((gap != 2'h0) ? gap - 2'h1 : 2'h0);
      end
   end
endmodule // mvld_stream_model

// File: bench/mvld_core_tb.sv
// Self-checking bench for the decoder control block
`timescale 1ns/10ps
module mvld_core_tb;
   import mvld_pkg::*;
   // ==========================================
   // Stimulus and observed signals
   logic sys_clk = 1'b0, rst_b = 1'b0, cmd_valid = 1'b0, stream_standard_select = 1'b0;
   logic in_load = 1'b0, hdr_load = 1'b0, coef_load = 1'b0, fill_restore_en = 1'b0, syntax_bad = 1'b0, slow = 1'b0;
   mvld_cmd_e cmd_code = CMD_NONE;
   logic [15:0] cmd_arg = 16'h0;
   logic [ST_W-1:0] interrupt_mask = 6'h0, status_clear = 6'h0, status;
   logic [7:0] picture_params = 8'h0, rd_data;
   logic [4:0] load_quant_scale = 5'h0;
   logic [6:0] fill_restore = 7'h0;
   mvld_buf_s in_load_val = 48'h0, hdr_load_val = 48'h0, coef_load_val = 48'h0, input_count, header_out, coef_out;
   logic rd_req, rd_valid, busy, irq;
   mvld_wr_s wr;
   logic [31:0] result, fifo_context, first_hdr = 32'hffff_ffff, first_data = 32'h0;
   int miscompares = 0, comparisons = 0;

   mvld_core i_mvld_core (.sys_clk, .rst_b, .cmd_valid, .cmd_code, .cmd_arg, .stream_standard_select,
      .interrupt_mask, .picture_params, .load_quant_scale, .status_clear, .in_load, .in_load_val, .hdr_load,
      .hdr_load_val, .coef_load, .coef_load_val, .fill_restore, .fill_restore_en, .rd_valid, .rd_data,
      .syntax_bad, .rd_req, .wr, .status, .irq, .busy, .result, .input_count, .header_out, .coef_out, .fifo_context);
   mvld_stream_model i_mvld_stream_model (.sys_clk, .rst_b, .rd_req, .slow, .rd_valid, .rd_data);

   always #50 sys_clk = ~sys_clk;
   // Sampled at the falling edge, where the write pulse has settled
   always @(negedge sys_clk) begin
      if (wr.valid === 1'b1 && wr.hdr === 1'b1 && first_hdr === 32'hffff_ffff) begin
         first_hdr = wr.addr;
         first_data = wr.data;
      end
   end

   // ==========================================
   // Access tasks
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         miscompares++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task automatic issue(input mvld_cmd_e c, input logic [15:0] a);
      @(negedge sys_clk);
      cmd_code = c;
      cmd_arg = a;
      cmd_valid = 1'b1;
      @(negedge sys_clk);
      cmd_valid = 1'b0;
   endtask
   // Buffer 0 input (bytes), 1 header, 2 coefficients (words)
   task automatic load(input int which, input logic [31:0] ad, input logic [15:0] cn);
      @(negedge sys_clk);
      {in_load_val, hdr_load_val, coef_load_val} = {3{ad, cn}};
      in_load = (which == 0);
      hdr_load = (which == 1);
      coef_load = (which == 2);
      @(negedge sys_clk);
      {in_load, hdr_load, coef_load} = 3'h0;
   endtask
   task automatic wait_bit(input int k);
      for (int n = 0; n < 3000 && status[k] !== 1'b1; n++) @(negedge sys_clk);
      check(32'(status[k]), 32'h1);
   endtask
   task automatic results;
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask

   // ==========================================
   // Scenarios
   initial begin
      repeat (6) @(negedge sys_clk);
      rst_b = 1'b1;
      check({status, irq, busy, wr.valid, rd_req}, 32'h0);
      load(0, 32'h100, 16'h4);
      issue(CMD_EXTRACT, 16'h8);
      wait_bit(ST_SUCCESS);
      check(result[7:0], i_mvld_stream_model.mem[0]);
      repeat (2) begin
         issue(CMD_PEEK, 16'h8);
         wait_bit(ST_SUCCESS);
         check(result[7:0], i_mvld_stream_model.mem[1]);
      end
      issue(CMD_EXTRACT, 16'h8);
      wait_bit(ST_SUCCESS);
      check(result[7:0], i_mvld_stream_model.mem[1]);
      issue(CMD_SKIP, 16'h8);
      wait_bit(ST_SUCCESS);
      // Only one byte left, so the word extract stalls
      issue(CMD_EXTRACT, 16'h20);
      wait_bit(ST_IN_EMPTY);
      check(input_count.addr, 32'h104);
      check(32'(input_count.count), 32'h0);
      load(0, 32'h200, 16'h3c);
      wait_bit(ST_SUCCESS);
      check(result, {i_mvld_stream_model.mem[3], i_mvld_stream_model.mem[4],
         i_mvld_stream_model.mem[5], i_mvld_stream_model.mem[6]});
      issue(CMD_SKIP, 16'h8);
      wait_bit(ST_SUCCESS);
      issue(CMD_SEEK, 16'h0);
      wait_bit(ST_SYNC);
      check(result[7:0], 8'hb7);
      check(fifo_context[23:0], 24'h000001);
      // Seek leaves the start code in the stream; take it out
      issue(CMD_EXTRACT, 16'h20);
      wait_bit(ST_SUCCESS);
      check(result, 32'h0000_01b7);
      // A four-word record exactly fills the header buffer
      slow = 1'b1;
      picture_params = 8'h5a;
      load_quant_scale = 5'h0b;
      load(1, 32'h1000, 16'h4);
      load(2, 32'h2000, 16'h40);
      issue(CMD_PARSE, 16'h1);
      wait_bit(ST_HDR_FULL);
      check(32'(status[ST_SUCCESS]), 32'h0);
      check(32'(header_out.count), 32'h0);
      check(32'(coef_out.count), 32'h40);
      check(first_data[31:16], {8'h5a, 3'h0, 5'h0b});
      load(1, 32'h1040, 16'h10);
      wait_bit(ST_SUCCESS);
      issue(CMD_DRAIN, 16'h0);
      wait_bit(ST_SUCCESS);
      check(first_hdr, 32'h1000);
      syntax_bad = 1'b1;
      issue(CMD_PARSE, 16'h1);
      wait_bit(ST_ERROR);
      syntax_bad = 1'b0;
      interrupt_mask = 6'h04;
      @(negedge sys_clk);
      check(32'(irq), 32'h1);
      interrupt_mask = 6'h3b;
      @(negedge sys_clk);
      check(32'(irq), 32'h0);
      status_clear = 6'h3f;
      @(negedge sys_clk);
      status_clear = 6'h0;
      @(negedge sys_clk);
      check(32'(status), 32'h0);
      // Six-word records fill a six-word buffer
      stream_standard_select = 1'b1;
      load(1, 32'h1100, 16'h6);
      load(2, 32'h2400, 16'h40);
      issue(CMD_PARSE, 16'h1);
      wait_bit(ST_HDR_FULL);
      issue(CMD_RESET, 16'h0);
      @(negedge sys_clk);
      check({status, busy}, 32'h0);
      check(input_count.addr, 32'h0);
      results;
   end
   initial begin
      #(100 * 60000);
      miscompares++;
      results;
   end
endmodule // mvld_core_tb
